// *** spi_buffered_port.sv ***
/*
  Buffered serial byte port: event flags, data register, two-entry
  receive buffer, one-entry transmit buffer and a slave shifter that runs
  on the link clock SCK. Assumes the register master never issues read
  and write together and that SCK only toggles while SS_N is low.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_buffered_port
  import spi_buf_pkg::*;
(
  // System clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Serial link
  input wire logic SCK,
  input wire logic SS_N,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  output logic MASTER_MODE
);

  typedef struct packed {
    logic enable;
    logic master;
    logic buffered;
    logic sel_ignore;
    logic [7:0] tx_buf;
    logic tx_full;
    logic [7:0] tx_stage;
    logic load_tgl;
    logic [7:0] rx_first;
    logic [7:0] rx_second;
    logic [1:0] rx_cnt;
    logic rxc_hid;
    logic txc;
    logic dre;
    logic takeover;
    logic ovf;
    logic ovf_pend;
    logic [7:0] rdata;
    logic ss_s1;
    logic ss_s2;
    logic ss_d;
    logic done_s1;
    logic done_s2;
    logic done_seen;
    logic ack_s1;
    logic ack_s2;
    logic link_rst;
  } sys_type;

  sys_type s_r;
  sys_type s_nxt;

  // Link-domain state
  logic [2:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] rx_hold_r;
  logic done_tgl_r;
  logic ack_r;
  logic load_s1_r;
  logic load_s2_r;

  logic done_ev;
  logic push_ev;
  logic start_ev;
  logic stage_free;
  logic tx_pending;
  logic rd_data;
  logic wr_data;
  logic wr_flags;
  logic [7:0] flag_vec;
  logic take;
  logic [7:0] first_byte;
  logic frame_clr;

  assign done_ev = s_r.done_s2 != s_r.done_seen;
  assign push_ev = done_ev && s_r.enable && !s_r.master;
  assign start_ev = s_r.ss_d && !s_r.ss_s2;
  assign stage_free = s_r.load_tgl == s_r.ack_s2;
  assign tx_pending = s_r.tx_full || !stage_free;
  assign rd_data = RD && (ADDR == DATA_OFS);
  assign wr_data = WR && (ADDR == DATA_OFS);
  assign wr_flags = WR && (ADDR == FLAGS_OFS);

  always_comb begin
    flag_vec = FLAGS_RESET;
    flag_vec[RXC_BIT] = (s_r.rx_cnt != 2'h0) && !s_r.rxc_hid;
    flag_vec[TXC_BIT] = s_r.txc;
    flag_vec[DRE_BIT] = s_r.dre;
    flag_vec[TAKEOVER_BIT] = s_r.takeover;
    flag_vec[OVF_BIT] = s_r.ovf;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ss_s1 = SS_N;
    s_nxt.ss_s2 = s_r.ss_s1;
    s_nxt.ss_d = s_r.ss_s2;
    s_nxt.done_s1 = done_tgl_r;
    s_nxt.done_s2 = s_r.done_s1;
    s_nxt.done_seen = s_r.done_s2;
    s_nxt.ack_s1 = ack_r;
    s_nxt.ack_s2 = s_r.ack_s1;
    s_nxt.link_rst = 1'b0;
    if (WR && ADDR == MODE_CTRL_OFS) begin
      s_nxt.enable = WDATA[ENABLE_BIT];
      s_nxt.master = WDATA[MASTER_BIT];
    end
    if (WR && ADDR == BUF_CTRL_OFS) begin
      s_nxt.buffered = WDATA[BUFFERED_BIT];
      s_nxt.sel_ignore = WDATA[SEL_IGNORE_BIT];
    end
    // Move into the link stage first so a same-cycle write lands behind it
    if (s_r.tx_full && stage_free) begin
      s_nxt.tx_stage = s_r.tx_buf;
      s_nxt.load_tgl = ~s_r.load_tgl;
      s_nxt.tx_full = 1'b0;
      s_nxt.dre = 1'b1;
    end
    if (wr_data) begin
      s_nxt.tx_buf = WDATA;
      s_nxt.tx_full = 1'b1;
      s_nxt.dre = 1'b0;
    end
    // Clearing a zero-written position is skipped, and hardware sets win below
    if (wr_flags) begin
      if (WDATA[RXC_BIT]) begin
        s_nxt.rxc_hid = 1'b1;
      end
      if (WDATA[TXC_BIT]) begin
        s_nxt.txc = 1'b0;
      end
      if (WDATA[TAKEOVER_BIT]) begin
        s_nxt.takeover = 1'b0;
      end
    end
    if (rd_data) begin
      s_nxt.rdata = s_r.rx_second;
      if (s_r.rx_cnt == RX_DEPTH) begin
        s_nxt.rx_second = s_r.rx_first;
        s_nxt.rx_cnt = 2'h1;
      end else begin
        s_nxt.rx_cnt = 2'h0;
      end
      s_nxt.ovf = 1'b0;
      s_nxt.ovf_pend = 1'b0;
    end else if (RD) begin
      unique case (ADDR)
        MODE_CTRL_OFS: begin
          s_nxt.rdata = DATA_RESET;
          s_nxt.rdata[ENABLE_BIT] = s_r.enable;
          s_nxt.rdata[MASTER_BIT] = s_r.master;
        end
        BUF_CTRL_OFS: begin
          s_nxt.rdata = DATA_RESET;
          s_nxt.rdata[BUFFERED_BIT] = s_r.buffered;
          s_nxt.rdata[SEL_IGNORE_BIT] = s_r.sel_ignore;
        end
        FLAGS_OFS: s_nxt.rdata = flag_vec;
        default: s_nxt.rdata = DATA_RESET;
      endcase
    end
    if (done_ev && !s_r.tx_full && stage_free && !wr_data) begin
      s_nxt.txc = 1'b1;
    end
    if (push_ev) begin
      s_nxt.rxc_hid = 1'b0;
      if (!s_r.buffered) begin
        s_nxt.rx_second = rx_hold_r;
        s_nxt.rx_cnt = 2'h1;
      end else if (s_nxt.rx_cnt == 2'h0) begin
        s_nxt.rx_second = rx_hold_r;
        s_nxt.rx_cnt = 2'h1;
      end else if (s_nxt.rx_cnt == 2'h1) begin
        s_nxt.rx_first = rx_hold_r;
        s_nxt.rx_cnt = RX_DEPTH;
      end else if (tx_pending) begin
        s_nxt.ovf = 1'b1;
      end else begin
        s_nxt.ovf_pend = 1'b1;
      end
    end
    if (start_ev && s_r.ovf_pend) begin
      s_nxt.ovf = 1'b1;
      s_nxt.ovf_pend = 1'b0;
    end
    if (s_r.master && !s_r.ss_s2 && !s_r.sel_ignore) begin
      s_nxt.master = 1'b0;
      s_nxt.takeover = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      s_r <= '0;
      s_r.link_rst <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RDATA = s_r.rdata;
  assign MASTER_MODE = s_r.master;

  // Link side: the stage word is held still until acknowledged, so the
  // link may read it once the synchronised request is seen.
  assign take = load_s2_r != ack_r;
  assign first_byte = take ? s_r.tx_stage : DUMMY_BYTE;
  assign frame_clr = s_r.link_rst | SS_N;
  assign MISO = (cnt_r == 3'h0) ? first_byte[7] : sh_r[7];
  assign MISO_OE = !SS_N && !s_r.master;

  // Frame position is wiped by the frame's own select, as SCK stops between frames
  always_ff @(posedge SCK or posedge frame_clr) begin
    if (frame_clr) begin
      cnt_r <= 3'h0;
      sh_r <= DATA_RESET;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h0) begin
        sh_r <= {first_byte[6:0], MOSI};
      end else begin
        sh_r <= {sh_r[6:0], MOSI};
      end
    end
  end

  always_ff @(posedge SCK or posedge s_r.link_rst) begin
    if (s_r.link_rst) begin
      rx_hold_r <= DATA_RESET;
      done_tgl_r <= 1'b0;
      ack_r <= 1'b0;
      load_s1_r <= 1'b0;
      load_s2_r <= 1'b0;
    end else begin
      load_s1_r <= s_r.load_tgl;
      load_s2_r <= load_s1_r;
      if (cnt_r == LAST_BIT_CNT) begin
        rx_hold_r <= {sh_r[6:0], MOSI};
        done_tgl_r <= ~done_tgl_r;
      end
      if (cnt_r == 3'h0 && take) begin
        ack_r <= load_s2_r;
      end
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  rxc_empty_a: assert property (s_r.rx_cnt == 2'h0 |-> !flag_vec[RXC_BIT])
    else $error("receive flag set with empty buffer");
  rxc_clear_a: assert property (wr_flags && WDATA[RXC_BIT] && !push_ev |=> !flag_vec[RXC_BIT])
    else $error("receive flag not cleared by write of one");
  txc_set_a: assert property (done_ev && !s_r.tx_full && stage_free && !wr_data |=> s_r.txc)
    else $error("transfer flag not set at idle end of byte");
  dre_move_a: assert property (s_r.tx_full && stage_free && !wr_data |=> s_r.dre && !s_r.tx_full)
    else $error("buffer-empty flag not set on move");
  dre_write_a: assert property (wr_data |=> !s_r.dre && s_r.tx_full)
    else $error("data write did not clear buffer-empty flag");
  reset_flags_a: assert property (@(posedge CLK_SYS) disable iff (1'b0)
    !RST_N |=> flag_vec == FLAGS_RESET && !s_r.dre)
    else $error("flags not zero after reset");
  takeover_a: assert property (s_r.master && !s_r.ss_s2 && !s_r.sel_ignore
    |=> !s_r.master && s_r.takeover)
    else $error("select takeover not taken");
  ignore_sel_a: assert property (s_r.sel_ignore && !s_r.takeover |=> !s_r.takeover)
    else $error("takeover flag set while select ignored");
  ovf_set_a: assert property (push_ev && s_r.buffered && s_r.rx_cnt == RX_DEPTH && !rd_data
    && tx_pending |=> s_r.ovf)
    else $error("overflow not flagged on third byte");
  ovf_defer_a: assert property (!s_r.ovf && s_r.ovf_pend && !start_ev && !push_ev |=> !s_r.ovf)
    else $error("overflow flagged before transfer start");
  ovf_hold_a: assert property (s_r.ovf && !rd_data |=> s_r.ovf)
    else $error("overflow dropped without data read");
  tx_load_a: assert property (wr_data |=> s_r.tx_buf == $past(WDATA))
    else $error("written byte not queued");
  rx_read_a: assert property (rd_data && s_r.rx_cnt == RX_DEPTH && !push_ev
    |=> RDATA == $past(s_r.rx_second) && s_r.rx_second == $past(s_r.rx_first) && s_r.rx_cnt == 2'h1)
    else $error("data read did not advance receive entries");
  single_entry_a: assert property (!s_r.buffered && push_ev |=> s_r.rx_cnt == 2'h1)
    else $error("unbuffered mode kept more than one entry");
  keep_zero_a: assert property (wr_flags && !WDATA[TXC_BIT] && s_r.txc |=> s_r.txc)
    else $error("zero write cleared transfer flag");

endmodule : spi_buffered_port
`default_nettype wire

// *** spi_buf_pkg.sv ***
/*
  Shared constants for the buffered serial byte port: register offsets,
  field positions, reset values and receive buffer depth.
  Assumes a byte-wide register port and a slave link clocked by SCK.
*/
`default_nettype none
package spi_buf_pkg;
  localparam logic [2:0] MODE_CTRL_OFS = 3'h0;
  localparam logic [2:0] BUF_CTRL_OFS = 3'h1;
  localparam logic [2:0] FLAGS_OFS = 3'h3;
  localparam logic [2:0] DATA_OFS = 3'h4;
  localparam int ENABLE_BIT = 0;
  localparam int MASTER_BIT = 5;
  localparam int SEL_IGNORE_BIT = 2;
  localparam int BUFFERED_BIT = 7;
  localparam int RXC_BIT = 7;
  localparam int TXC_BIT = 6;
  localparam int DRE_BIT = 5;
  localparam int TAKEOVER_BIT = 4;
  localparam int OVF_BIT = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  localparam logic [2:0] LAST_BIT_CNT = 3'h7;
  localparam logic [1:0] RX_DEPTH = 2'h2;
endpackage : spi_buf_pkg
`default_nettype wire

// *** spi_link_master.sv ***
/*
  Remote link master model: sends queued bytes on MOSI under SS_N and
  collects what comes back on MISO.
  Assumes the port is a mode-0 slave that shifts MSB first.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_link_master (
  // Link pins
  output logic sck,
  output logic ss_n,
  output logic mosi,
  input wire logic miso
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];

  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b1;
  end

  // SCK stands still between frames; a frame of zero bytes pulses SS_N and inverts MOSI without clocking SCK
  task automatic frame(input int n);
    logic [7:0] b;
    #7;
    ss_n = 1'b0;
    #100;
    repeat (n) begin
      b = tx_q.pop_front();
      for (int i = 7; i >= 0; i--) begin
        mosi = b[i];
        #62.5;
        b[i] = miso;
        sck = 1'b1;
        #62.5;
        sck = 1'b0;
      end
      rx_q.push_back(b);
    end
    #100;
    ss_n = 1'b1;
    // Released line shows the inverse so a stale bit is never mistaken for data
    mosi = ~mosi;
  endtask : frame
endmodule : spi_link_master
`default_nettype wire

// *** spi_buffered_port_tb.sv ***
/*
  Self-checking bench for the buffered serial byte port.
  Assumes the link master model drives SCK at 125 ns only inside frames.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %0t: got %h want %h", $time, a, e); end end
module spi_buffered_port_tb;
  import spi_buf_pkg::*;
  logic CLK_SYS, RST_N, WR, RD, SCK, SS_N, MOSI, MISO, MISO_OE, MASTER_MODE;
  logic [2:0] ADDR;
  logic [7:0] WDATA, RDATA, w;
  logic [7:0] b[3];
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic rd_d = 1'b0;
  int n_mismatch = 0, checked = 0, cycles = 0, seed = 26;

  spi_buffered_port spi_buffered_port_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SCK(SCK), .SS_N(SS_N), .MOSI(MOSI), .MISO(MISO),
    .MISO_OE(MISO_OE), .MASTER_MODE(MASTER_MODE));
  spi_link_master spi_link_master_i (.sck(SCK), .ss_n(SS_N), .mosi(MOSI), .miso(MISO));

  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  // Read data appear in the cycle after the strobe and hold until the next read strobe
  always @(posedge CLK_SYS) begin
    rd_d <= RD;
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK(RDATA & e[15:8], e[7:0])
    end
  end

  // Every SCK edge falls inside a slave frame, so the output must be driven
  always @(posedge SCK) begin
    `CHK(MISO_OE, 1'b1)
  end

  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    {WR, RD} <= 2'b10;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK_SYS);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] x);
    exp_q.push_back({m, x});
    {WR, RD} <= 2'b01;
    ADDR <= a;
    @(posedge CLK_SYS);
  endtask : rd

  task automatic idle(input int n);
    {WR, RD} <= 2'b00;
    repeat (n) @(posedge CLK_SYS);
  endtask : idle

  task automatic wrap_up;
    $display("Counts: checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    RST_N = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 3'h0;
    WDATA = 8'h00;
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(posedge CLK_SYS);
    rd(FLAGS_OFS, 8'hFF, FLAGS_RESET);
    rd(DATA_OFS, 8'hFF, DATA_RESET);
    rd(3'h2, 8'hFF, 8'h00);
    wr(MODE_CTRL_OFS, 8'h01);
    wr(BUF_CTRL_OFS, 8'h80);
    w = 8'($random(seed));
    wr(DATA_OFS, w);
    idle(4);
    $display("Test reset and setup done");
    for (int i = 0; i < 3; i++) b[i] = 8'($random(seed));
    spi_link_master_i.tx_q = {b[0], b[1]};
    spi_link_master_i.frame(2);
    idle(10);
    `CHK(spi_link_master_i.rx_q[0], DUMMY_BYTE)
    `CHK(spi_link_master_i.rx_q[1], w)
    rd(FLAGS_OFS, 8'hE1, 8'hE0);
    rd(DATA_OFS, 8'hFF, b[0]);
    rd(DATA_OFS, 8'hFF, b[1]);
    rd(FLAGS_OFS, 8'h80, 8'h00);
    wr(FLAGS_OFS, 8'h00);
    rd(FLAGS_OFS, 8'h40, 8'h40);
    wr(FLAGS_OFS, 8'h40);
    rd(FLAGS_OFS, 8'h40, 8'h00);
    idle(2);
    $display("Test two-byte frame done");
    for (int i = 0; i < 3; i++) b[i] = 8'($random(seed));
    spi_link_master_i.tx_q = {b[0], b[1], b[2]};
    spi_link_master_i.frame(3);
    idle(10);
    rd(FLAGS_OFS, 8'h81, 8'h80);
    idle(1);
    spi_link_master_i.frame(0);
    idle(10);
    rd(FLAGS_OFS, 8'h01, 8'h01);
    rd(DATA_OFS, 8'hFF, b[0]);
    rd(FLAGS_OFS, 8'h01, 8'h00);
    wr(FLAGS_OFS, 8'h80);
    rd(FLAGS_OFS, 8'h80, 8'h00);
    rd(DATA_OFS, 8'hFF, b[1]);
    idle(2);
    $display("Test overflow done");
    wr(MODE_CTRL_OFS, 8'h21);
    idle(2);
    spi_link_master_i.frame(0);
    idle(6);
    `CHK(MASTER_MODE, 1'b0)
    rd(FLAGS_OFS, 8'h10, 8'h10);
    wr(FLAGS_OFS, 8'h10);
    rd(FLAGS_OFS, 8'h10, 8'h00);
    wr(BUF_CTRL_OFS, 8'h84);
    wr(MODE_CTRL_OFS, 8'h21);
    idle(2);
    spi_link_master_i.frame(0);
    idle(6);
    `CHK(MASTER_MODE, 1'b1)
    rd(FLAGS_OFS, 8'h10, 8'h00);
    idle(3);
    $display("Test select takeover done");
    wr(MODE_CTRL_OFS, 8'h01);
    idle(2);
    for (int i = 0; i < 3; i++) b[i] = 8'($random(seed));
    spi_link_master_i.tx_q = {b[0], b[1], b[2]};
    spi_link_master_i.frame(2);
    idle(10);
    // Staged byte stays unacknowledged while SCK is idle, so data is pending
    wr(DATA_OFS, w);
    idle(4);
    spi_link_master_i.frame(1);
    idle(10);
    `CHK(spi_link_master_i.rx_q[$], DUMMY_BYTE)
    rd(FLAGS_OFS, 8'h81, 8'h81);
    rd(DATA_OFS, 8'hFF, b[0]);
    rd(DATA_OFS, 8'hFF, b[1]);
    wr(BUF_CTRL_OFS, 8'h00);
    spi_link_master_i.tx_q = {b[2], b[0]};
    spi_link_master_i.frame(2);
    idle(10);
    rd(DATA_OFS, 8'hFF, b[0]);
    rd(FLAGS_OFS, 8'h81, 8'h00);
    idle(2);
    $display("Test overrun and single entry done");
    wrap_up();
  end
endmodule : spi_buffered_port_tb
`default_nettype wire
